// >>> rtl/msc_regs.sv
// ****************************************************************
// misc system control register bank, ahb-lite slave
// ****************************************************************

module msc_regs (
   // clock and reset
   input  wire logic               REF_CLK,
   input  wire logic               RST_N,
   // ahb-lite slave
   input  wire logic               HSEL,
   input  wire logic [31:0]        HADDR,
   input  wire logic [1:0]         HTRANS,
   input  wire logic               HWRITE,
   input  wire logic [2:0]         HSIZE,
   input  wire logic [31:0]        HWDATA,
   input  wire logic               HREADY,
   output logic      [31:0]        HRDATA,
   output logic                    HREADYOUT,
   output logic                    HRESP,
   // cpu program counter side
   input  wire logic               PC_LOW_WR,
   input  wire logic               PC_HIGH_LOAD,
   input  wire logic [3:0]         PC_HIGH_IN,
   input  wire logic [3:0]         PC_HIGH_LATCH,
   output logic      [3:0]         PC_HIGH,
   output logic                    PC_HI_HOLD,
   // configuration data
   input  wire msc_pkg::msc_cfg_t  CFG,
   // trim and control outputs
   output msc_pkg::msc_trim_t      TRIM,
   output logic [7:0]              BG_TRIM_2V
);

   // ****************************************************************
   // reset release
   // ****************************************************************
   logic rst_s1_r;
   logic rst_n_s;

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         rst_s1_r <= 1'b0;
         rst_n_s  <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_n_s  <= rst_s1_r;
      end
   end

   // ****************************************************************
   // bus address phase
   // ****************************************************************
   logic       wr_pend_r;
   logic       rd_pend_r;
   logic [8:0] idx_r;
   logic       hready_r;
   logic [31:0] hrdata_r;

   wire        addr_take = HSEL && HREADY && HTRANS[1];
   wire        rd_take   = addr_take && !HWRITE;
   wire        wr_take   = addr_take && HWRITE;
   wire [8:0]  addr_idx  = HADDR[10:2];

   always_ff @(posedge REF_CLK or negedge rst_n_s) begin
      if (!rst_n_s) begin
         wr_pend_r <= 1'b0;
         rd_pend_r <= 1'b0;
         idx_r     <= 9'h000;
      end else begin
         wr_pend_r <= wr_take;
         rd_pend_r <= rd_take;
         if (addr_take) begin
            idx_r <= addr_idx;
         end
      end
   end

   // ****************************************************************
   // decode in data phase
   // ****************************************************************
   wire       sel_pch  = idx_r == msc_pkg::IDX_PC_HIGH_SRC;
   wire       sel_bg   = idx_r == msc_pkg::IDX_BG_TRIM_LOW;
   wire       sel_fosc = idx_r == msc_pkg::IDX_FOSC_TRIM;
   wire       sel_bg2  = idx_r == msc_pkg::IDX_BG_TRIM_2V;
   wire       sel_reg  = idx_r == msc_pkg::IDX_REG_OUT;
   wire       sel_dly  = idx_r == msc_pkg::IDX_ROM_DLY;
   wire       sel_fine = idx_r == msc_pkg::IDX_FOSC_FINE;
   wire       sel_ram  = idx_r >= msc_pkg::IDX_RAM_FIRST && idx_r <= msc_pkg::IDX_RAM_LAST;
   wire [8:0] ram_off  = idx_r - msc_pkg::IDX_RAM_FIRST;
   wire [6:0] ram_idx  = ram_off[6:0];
   wire [7:0] wbyte    = HWDATA[7:0];

   wire wr_pch  = wr_pend_r && sel_pch;
   wire wr_bg   = wr_pend_r && sel_bg;
   wire wr_fosc = wr_pend_r && sel_fosc;
   wire wr_reg  = wr_pend_r && sel_reg;
   wire wr_dly  = wr_pend_r && sel_dly;
   wire wr_fine = wr_pend_r && sel_fine;
   wire wr_ram  = wr_pend_r && sel_ram;

   // ****************************************************************
   // pc high source control
   // ****************************************************************
   logic       hold_r;
   logic       hold_nxt;
   logic [3:0] pc_high_r;
   logic [3:0] pc_high_nxt;

   assign hold_nxt    = wr_pch ? (wbyte == msc_pkg::HOLD_KEY) : hold_r;
   assign pc_high_nxt = PC_LOW_WR    ? (hold_r ? pc_high_r : PC_HIGH_LATCH) :
                        PC_HIGH_LOAD ? PC_HIGH_IN : pc_high_r;

   always_ff @(posedge REF_CLK or negedge rst_n_s) begin
      if (!rst_n_s) begin
         hold_r    <= msc_pkg::HOLD_RESET;
         pc_high_r <= msc_pkg::PC_HI_RESET;
      end else begin
         hold_r    <= hold_nxt;
         pc_high_r <= pc_high_nxt;
      end
   end

   // ****************************************************************
   // trim and control registers
   // ****************************************************************
   logic                            cfg_load_r;
   logic [msc_pkg::BG_TRIM_W-1:0]   bg_r;
   logic [msc_pkg::FOSC_TRIM_W-1:0] fosc_r;
   logic [msc_pkg::BG2_TRIM_W-1:0]  bg2_r;
   logic [msc_pkg::FINE_W-1:0]      fine_r;
   logic [msc_pkg::DLY_W-1:0]       dly_r;
   logic                            reg_out_r;

   // configuration values caught on the first edge after release
   always_ff @(posedge REF_CLK or negedge rst_n_s) begin
      if (!rst_n_s) begin
         cfg_load_r <= 1'b1;
         bg_r       <= '0;
         fosc_r     <= '0;
         bg2_r      <= '0;
      end else begin
         cfg_load_r <= 1'b0;
         if (cfg_load_r) begin
            bg_r   <= CFG.bg_trim;
            fosc_r <= CFG.fosc_trim;
            bg2_r  <= CFG.bg2_trim;
         end else begin
            if (wr_bg) begin
               bg_r <= wbyte[msc_pkg::BG_TRIM_W-1:0];
            end
            if (wr_fosc) begin
               fosc_r <= wbyte[msc_pkg::FOSC_TRIM_W-1:0];
            end
         end
      end
   end

   always_ff @(posedge REF_CLK or negedge rst_n_s) begin
      if (!rst_n_s) begin
         fine_r    <= msc_pkg::FINE_RESET;
         dly_r     <= msc_pkg::DLY_RESET;
         reg_out_r <= msc_pkg::REG_OUT_RST;
      end else begin
         if (wr_fine) begin
            fine_r <= wbyte[msc_pkg::FINE_W-1:0];
         end
         if (wr_dly) begin
            dly_r <= wbyte[msc_pkg::DLY_W-1:0];
         end
         if (wr_reg) begin
            reg_out_r <= wbyte[0];
         end
      end
   end

   // ****************************************************************
   // general ram bank
   // ****************************************************************
   logic [7:0] ram_rdata;

   msc_ram #(
      .DEPTH (msc_pkg::RAM_DEPTH),
      .AW    (msc_pkg::RAM_AW),
      .DW    (msc_pkg::DATA_W)
   ) u_ram (
      .clk     (REF_CLK),
      .wr_en   (wr_ram),
      .wr_addr (ram_idx),
      .wr_data (wbyte),
      .rd_addr (ram_idx),
      .rd_data (ram_rdata)
   );

   // ****************************************************************
   // read mux and response
   // ****************************************************************
   logic [7:0] rd_val;

   assign rd_val = sel_pch  ? {4'h0, pc_high_r} :
                   sel_bg   ? {3'h0, bg_r} :
                   sel_fosc ? {1'h0, fosc_r} :
                   sel_bg2  ? bg2_r :
                   sel_reg  ? {7'h00, reg_out_r} :
                   sel_dly  ? {6'h00, dly_r} :
                   sel_fine ? {3'h0, fine_r} :
                   sel_ram  ? ram_rdata : 8'h00;

   // one wait state on reads so a write just before is seen
   always_ff @(posedge REF_CLK or negedge rst_n_s) begin
      if (!rst_n_s) begin
         hready_r <= 1'b1;
         hrdata_r <= 32'h0000_0000;
      end else begin
         hready_r <= !rd_take;
         if (rd_pend_r) begin
            hrdata_r <= {24'h00_0000, rd_val};
         end
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   assign HRDATA               = hrdata_r;
   assign HREADYOUT            = hready_r;
   assign HRESP                = msc_pkg::HRESP_OKAY;
   assign PC_HIGH              = pc_high_r;
   assign PC_HI_HOLD           = hold_r;
   assign BG_TRIM_2V           = bg2_r;
   assign TRIM                 = '{
      bg_trim    : bg_r,
      fosc_trim  : fosc_r,
      fosc_fine  : fine_r,
      rom_dly    : dly_r,
      reg_out_en : reg_out_r
   };

   // ****************************************************************
   // checks
   // ****************************************************************
   chk_hold_set: assert property (
      @(posedge REF_CLK) disable iff (!rst_n_s)
      wr_pch && wbyte == 8'h1C |=> PC_HI_HOLD)
      else $error("hold flag not set by key write");

   chk_hold_clear: assert property (
      @(posedge REF_CLK) disable iff (!rst_n_s)
      wr_pch && wbyte != 8'h1C |=> !PC_HI_HOLD)
      else $error("hold flag not cleared by other write");

   chk_pch_keep: assert property (
      @(posedge REF_CLK) disable iff (!rst_n_s)
      PC_LOW_WR && PC_HI_HOLD |=> $stable(PC_HIGH))
      else $error("pc high changed while held");

   chk_pch_latch: assert property (
      @(posedge REF_CLK) disable iff (!rst_n_s)
      PC_LOW_WR && !PC_HI_HOLD |=> PC_HIGH == $past(PC_HIGH_LATCH))
      else $error("pc high not loaded from latch");

   chk_reset_vals: assert property (
      @(posedge REF_CLK)
      $rose(rst_n_s) |-> !PC_HI_HOLD && TRIM.rom_dly == 2'h0 && TRIM.fosc_fine == 5'h00)
      else $error("reset values wrong");

   chk_pch_read: assert property (
      @(posedge REF_CLK) disable iff (!rst_n_s)
      rd_pend_r && sel_pch |=> HREADYOUT && HRDATA == {28'h000_0000, $past(PC_HIGH)})
      else $error("pc high read back wrong");

   chk_cfg_load: assert property (
      @(posedge REF_CLK) disable iff (!rst_n_s)
      cfg_load_r |=> TRIM.bg_trim == $past(CFG.bg_trim) && TRIM.fosc_trim == $past(CFG.fosc_trim))
      else $error("trim not loaded from configuration");

   chk_factory_ro: assert property (
      @(posedge REF_CLK) disable iff (!rst_n_s)
      !cfg_load_r ##1 wr_pend_r && sel_bg2 |=> $stable(BG_TRIM_2V))
      else $error("factory trim changed by write");

   chk_dly_write: assert property (
      @(posedge REF_CLK) disable iff (!rst_n_s)
      wr_dly |=> TRIM.rom_dly == $past(HWDATA[1:0]))
      else $error("rom delay field not written");

   chk_reg_out: assert property (
      @(posedge REF_CLK) disable iff (!rst_n_s)
      wr_reg |=> TRIM.reg_out_en == $past(HWDATA[0]))
      else $error("regulator output bit not written");

   chk_upper_zero: assert property (
      @(posedge REF_CLK) disable iff (!rst_n_s)
      rd_pend_r && (sel_dly || sel_fine || sel_reg) |=> HRDATA[31:5] == 27'h000_0000)
      else $error("undefined bits read nonzero");

   chk_read_wait: assert property (
      @(posedge REF_CLK) disable iff (!rst_n_s)
      rd_take |=> !HREADYOUT ##1 HREADYOUT)
      else $error("read wait state wrong");

   chk_pch_load: assert property (
      @(posedge REF_CLK) disable iff (!rst_n_s)
      PC_HIGH_LOAD && !PC_LOW_WR |=> PC_HIGH == $past(PC_HIGH_IN))
      else $error("pc high not loaded by pc update");

   chk_bg_write: assert property (
      @(posedge REF_CLK) disable iff (!rst_n_s)
      wr_bg && !cfg_load_r |=> TRIM.bg_trim == $past(HWDATA[4:0]))
      else $error("bandgap trim not written");

   chk_fosc_write: assert property (
      @(posedge REF_CLK) disable iff (!rst_n_s)
      wr_fosc && !cfg_load_r |=> TRIM.fosc_trim == $past(HWDATA[6:0]))
      else $error("oscillator trim not written");

   chk_fine_write: assert property (
      @(posedge REF_CLK) disable iff (!rst_n_s)
      wr_fine |=> TRIM.fosc_fine == $past(HWDATA[4:0]))
      else $error("fine step field not written");

   chk_rdata_stand: assert property (
      @(posedge REF_CLK) disable iff (!rst_n_s)
      !rd_pend_r |=> $stable(HRDATA))
      else $error("read data changed without a read");

   cov_key_write: cover property (@(posedge REF_CLK) disable iff (!rst_n_s) wr_pch && wbyte == 8'h1C);
   cov_held_pcl:  cover property (@(posedge REF_CLK) disable iff (!rst_n_s) PC_LOW_WR && PC_HI_HOLD);
   cov_ram_read:  cover property (@(posedge REF_CLK) disable iff (!rst_n_s) rd_pend_r && sel_ram);
   cov_dly_8ns:   cover property (@(posedge REF_CLK) disable iff (!rst_n_s) wr_dly && wbyte[1:0] == 2'h3);
   cov_clr_write: cover property (@(posedge REF_CLK) disable iff (!rst_n_s) wr_pch && wbyte != 8'h1C);

endmodule : msc_regs

// >>> rtl/msc_pkg.sv
// ****************************************************************
// misc system control constants and types
// ****************************************************************
package msc_pkg;

   // ****************************************************************
   // register indices (byte address is four times the index)
   // ****************************************************************
   localparam logic [8:0] IDX_PC_HIGH_SRC = 9'h10C;
   localparam logic [8:0] IDX_BG_TRIM_LOW = 9'h10E;
   localparam logic [8:0] IDX_FOSC_TRIM   = 9'h10F;
   localparam logic [8:0] IDX_BG_TRIM_2V  = 9'h111;
   localparam logic [8:0] IDX_REG_OUT     = 9'h112;
   localparam logic [8:0] IDX_ROM_DLY     = 9'h113;
   localparam logic [8:0] IDX_FOSC_FINE   = 9'h114;
   localparam logic [8:0] IDX_RAM_FIRST   = 9'h120;
   localparam logic [8:0] IDX_RAM_LAST    = 9'h16F;

   // ****************************************************************
   // field layout and reset values
   // ****************************************************************
   localparam int         PC_HI_W      = 4;
   localparam int         BG_TRIM_W    = 5;
   localparam int         FOSC_TRIM_W  = 7;
   localparam int         BG2_TRIM_W   = 8;
   localparam int         FINE_W       = 5;
   localparam int         DLY_W        = 2;
   localparam int         RAM_DEPTH    = 80;
   localparam int         RAM_AW       = 7;
   localparam int         DATA_W       = 8;
   localparam logic [7:0] HOLD_KEY     = 8'h1C;
   localparam logic [4:0] FINE_RESET   = 5'h00;
   localparam logic [1:0] DLY_RESET    = 2'h0;
   localparam logic       REG_OUT_RST  = 1'b0;
   localparam logic       HOLD_RESET   = 1'b0;
   localparam logic [3:0] PC_HI_RESET  = 4'h0;

   // ****************************************************************
   // rom read strobe delay encodings
   // ****************************************************************
   localparam logic [1:0] DLY_20NS     = 2'h0;
   localparam logic [1:0] DLY_16NS     = 2'h1;
   localparam logic [1:0] DLY_12NS     = 2'h2;
   localparam logic [1:0] DLY_8NS      = 2'h3;

   // ****************************************************************
   // bus constants
   // ****************************************************************
   localparam logic [1:0] HTRANS_IDLE   = 2'h0;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic       HRESP_OKAY    = 1'b0;

   // ****************************************************************
   // carriers
   // ****************************************************************
   typedef struct packed {
      logic [BG_TRIM_W-1:0]   bg_trim;
      logic [FOSC_TRIM_W-1:0] fosc_trim;
      logic [FINE_W-1:0]      fosc_fine;
      logic [DLY_W-1:0]       rom_dly;
      logic                   reg_out_en;
   } msc_trim_t;

   typedef struct packed {
      logic [BG_TRIM_W-1:0]   bg_trim;
      logic [FOSC_TRIM_W-1:0] fosc_trim;
      logic [BG2_TRIM_W-1:0]  bg2_trim;
   } msc_cfg_t;

endpackage : msc_pkg

// >>> rtl/msc_ram.sv
// ****************************************************************
// general ram bank, flip-flop storage, no reset
// ****************************************************************
module msc_ram #(
   parameter int DEPTH = msc_pkg::RAM_DEPTH,
   parameter int AW    = msc_pkg::RAM_AW,
   parameter int DW    = msc_pkg::DATA_W
) (
   // clock
   input  wire logic          clk,
   // write side
   input  wire logic          wr_en,
   input  wire logic [AW-1:0] wr_addr,
   input  wire logic [DW-1:0] wr_data,
   // read side
   input  wire logic [AW-1:0] rd_addr,
   output logic      [DW-1:0] rd_data
);

   logic [DW-1:0] mem_r [DEPTH];

   // contents undefined after reset
   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem_r[wr_addr] <= wr_data;
      end
   end

   assign rd_data = mem_r[rd_addr];

endmodule : msc_ram

// >>> test/msc_cpu_model.sv
// ****************************************************************
// cpu program counter side model
// ****************************************************************
module msc_cpu_model (
   // clock
   input  wire logic       clk,
   // program counter side
   output logic            pc_low_wr,
   output logic            pc_high_load,
   output logic [3:0]      pc_high_in,
   output logic [3:0]      pc_high_latch
);
   timeunit 1ns;
   timeprecision 100ps;

   initial begin
      pc_low_wr     = 1'b0;
      pc_high_load  = 1'b0;
      pc_high_in    = 4'h0;
      pc_high_latch = 4'h0;
   end

   // one-cycle pc low write; latch flips afterwards so stale values never match
   task automatic low_write(input logic [3:0] lat);
      pc_low_wr     <= 1'b1;
      pc_high_latch <= lat;
      @(posedge clk);
      pc_low_wr     <= 1'b0;
      pc_high_latch <= ~lat;
   endtask : low_write

   // ordinary pc update
   task automatic high_load(input logic [3:0] v);
      pc_high_load <= 1'b1;
      pc_high_in   <= v;
      @(posedge clk);
      pc_high_load <= 1'b0;
      pc_high_in   <= ~v;
   endtask : high_load

endmodule : msc_cpu_model

// >>> test/tb.sv
// ****************************************************************
// misc system control register bank testbench
// ****************************************************************
module tb;
   timeunit 1ns;
   timeprecision 100ps;

   logic                ref_clk = 1'b0;
   logic                rst_n   = 1'b0;
   logic                hsel    = 1'b0;
   logic [31:0]         haddr   = 32'h0;
   logic [1:0]          htrans  = msc_pkg::HTRANS_IDLE;
   logic                hwrite  = 1'b0;
   logic [2:0]          hsize   = 3'h2;
   logic [31:0]         hwdata  = 32'h0;
   logic [31:0]         hrdata;
   logic                hreadyout;
   logic                hresp;
   logic                pc_low_wr;
   logic                pc_high_load;
   logic [3:0]          pc_high_in;
   logic [3:0]          pc_high_latch;
   logic [3:0]          pc_high;
   logic                pc_hi_hold;
   msc_pkg::msc_cfg_t   cfg;
   msc_pkg::msc_trim_t  trim;
   logic [7:0]          bg_trim_2v;
   int                  miscompares = 0;
   int                  tests_run   = 0;
   logic [7:0]          sh [logic [8:0]];
   logic                hold_exp;
   logic [3:0]          pc_exp;
   logic [31:0]         rd;
   logic [8:0]          idx;
   logic [8:0]          rlist [8] = '{9'h10E, 9'h10F, 9'h111, 9'h112, 9'h113, 9'h114, 9'h110, 9'h10D};
   logic [8:0]          ram [12];
   logic [1:0]          dly_codes [4] = '{msc_pkg::DLY_20NS, msc_pkg::DLY_16NS, msc_pkg::DLY_12NS, msc_pkg::DLY_8NS};

   initial forever #5 ref_clk = ~ref_clk;

   msc_regs msc_regs_i (.REF_CLK(ref_clk), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
      .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
      .HREADYOUT(hreadyout), .HRESP(hresp), .PC_LOW_WR(pc_low_wr), .PC_HIGH_LOAD(pc_high_load),
      .PC_HIGH_IN(pc_high_in), .PC_HIGH_LATCH(pc_high_latch), .PC_HIGH(pc_high), .PC_HI_HOLD(pc_hi_hold),
      .CFG(cfg), .TRIM(trim), .BG_TRIM_2V(bg_trim_2v));

   msc_cpu_model msc_cpu_model_i (.clk(ref_clk), .pc_low_wr(pc_low_wr), .pc_high_load(pc_high_load),
      .pc_high_in(pc_high_in), .pc_high_latch(pc_high_latch));

   // ****************************************************************
   // expectations and compares
   // ****************************************************************
   function automatic logic [7:0] wmask(input logic [8:0] i);
      if (i >= msc_pkg::IDX_RAM_FIRST && i <= msc_pkg::IDX_RAM_LAST) return 8'hFF;
      case (i)
         msc_pkg::IDX_BG_TRIM_LOW, msc_pkg::IDX_FOSC_FINE: return 8'h1F;
         msc_pkg::IDX_FOSC_TRIM: return 8'h7F;
         msc_pkg::IDX_REG_OUT: return 8'h01;
         msc_pkg::IDX_ROM_DLY: return 8'h03;
         default: return 8'h00;
      endcase
   endfunction : wmask

   function automatic logic [31:0] exp_rd(input logic [8:0] i);
      if (i == msc_pkg::IDX_PC_HIGH_SRC) return {28'h0, pc_exp};
      if (i == msc_pkg::IDX_BG_TRIM_2V) return {24'h0, cfg.bg2_trim};
      if (sh.exists(i)) return {24'h0, sh[i]};
      return 32'h0;
   endfunction : exp_rd

   task automatic cmp_rd(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp_rd

   task automatic cmp_pin(input string what, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp_pin

   // ****************************************************************
   // bus and pc side tasks, entered right after a rising edge
   // ****************************************************************
   task automatic bus(input logic w, input logic [8:0] i, input logic [31:0] wd);
      hsel   <= 1'b1;
      htrans <= msc_pkg::HTRANS_NONSEQ;
      haddr  <= {21'h0, i, 2'b00};
      hwrite <= w;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      htrans <= msc_pkg::HTRANS_IDLE;
      hwdata <= wd;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      rd = hrdata;
      cmp_pin("response", {7'h0, msc_pkg::HRESP_OKAY}, {7'h0, hresp});
   endtask : bus

   task automatic wr(input logic [8:0] i, input logic [31:0] d);
      bus(1'b1, i, d);
      if (wmask(i) != 8'h00) sh[i] = d[7:0] & wmask(i);
      if (i == msc_pkg::IDX_PC_HIGH_SRC) hold_exp = (d[7:0] == msc_pkg::HOLD_KEY);
   endtask : wr

   task automatic rd_chk(input logic [8:0] i);
      bus(1'b0, i, 32'h0);
      cmp_rd($sformatf("read index %h", i), exp_rd(i), rd);
   endtask : rd_chk

   task automatic pc_chk();
      @(posedge ref_clk);
      cmp_pin("pc high", {4'h0, pc_exp}, {4'h0, pc_high});
      cmp_pin("hold flag", {7'h0, hold_exp}, {7'h0, pc_hi_hold});
   endtask : pc_chk

   task automatic pcw(input logic [3:0] lat);
      msc_cpu_model_i.low_write(lat);
      if (!hold_exp) pc_exp = lat;
      pc_chk();
   endtask : pcw

   task automatic do_reset(input int n);
      rst_n <= 1'b0;
      repeat (n) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge ref_clk);
      sh.delete();
      sh[msc_pkg::IDX_BG_TRIM_LOW] = {3'h0, cfg.bg_trim};
      sh[msc_pkg::IDX_FOSC_TRIM]   = {1'h0, cfg.fosc_trim};
      sh[msc_pkg::IDX_REG_OUT]     = 8'h00;
      sh[msc_pkg::IDX_ROM_DLY]     = 8'h00;
      sh[msc_pkg::IDX_FOSC_FINE]   = 8'h00;
      hold_exp = 1'b0;
      pc_exp   = 4'h0;
   endtask : do_reset

   task automatic finish_test();
      $display("compares %0d, mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : finish_test

   // ****************************************************************
   // tests
   // ****************************************************************
   initial begin
      void'($urandom(32'h31bd));
      cfg = 20'($urandom);
      do_reset(10);
      foreach (rlist[k]) rd_chk(rlist[k]);
      rd_chk(msc_pkg::IDX_PC_HIGH_SRC);
      cmp_pin("hold after reset", 8'h00, {7'h0, pc_hi_hold});
      cmp_pin("factory trim port", cfg.bg2_trim, bg_trim_2v);
      cmp_pin("osc trim port", {1'h0, cfg.fosc_trim}, {1'h0, trim.fosc_trim});
      $display("test reset_values done");

      for (int n = 0; n < 8; n++) begin
         foreach (rlist[k]) begin
            wr(rlist[k], (n == 0) ? 32'hFFFF_FFFF : $urandom);
            rd_chk(rlist[k]);
         end
      end
      cmp_pin("bandgap trim port", sh[msc_pkg::IDX_BG_TRIM_LOW], {3'h0, trim.bg_trim});
      cmp_pin("fine step port", sh[msc_pkg::IDX_FOSC_FINE], {3'h0, trim.fosc_fine});
      cmp_pin("regulator out port", sh[msc_pkg::IDX_REG_OUT], {7'h0, trim.reg_out_en});
      bus(1'b0, msc_pkg::IDX_BG_TRIM_2V, 32'h0);
      wr(msc_pkg::IDX_BG_TRIM_LOW, rd);
      rd_chk(msc_pkg::IDX_BG_TRIM_LOW);
      $display("test register_access done");

      // one clock only here, so no slow-clock switch precedes the change
      foreach (dly_codes[c]) begin
         wr(msc_pkg::IDX_ROM_DLY, {30'h0, dly_codes[c]});
         rd_chk(msc_pkg::IDX_ROM_DLY);
         cmp_pin("rom delay port", {6'h0, dly_codes[c]}, {6'h0, trim.rom_dly});
      end
      $display("test rom_delay done");

      pcw(4'($urandom));
      wr(msc_pkg::IDX_PC_HIGH_SRC, {24'h0, msc_pkg::HOLD_KEY});
      pc_chk();
      repeat (4) pcw(4'($urandom));
      msc_cpu_model_i.high_load(4'hA);
      pc_exp = 4'hA;
      pc_chk();
      rd_chk(msc_pkg::IDX_PC_HIGH_SRC);
      wr(msc_pkg::IDX_PC_HIGH_SRC, 32'h1D);
      pc_chk();
      pcw(4'h6);
      for (int n = 0; n < 4; n++) begin
         wr(msc_pkg::IDX_PC_HIGH_SRC, {24'h0, msc_pkg::HOLD_KEY});
         wr(msc_pkg::IDX_PC_HIGH_SRC, {24'h0, msc_pkg::HOLD_KEY ^ 8'($urandom_range(255, 1))});
         pcw(4'($urandom));
      end
      wr(msc_pkg::IDX_PC_HIGH_SRC, {24'h0, msc_pkg::HOLD_KEY});
      pc_chk();
      do_reset(2);
      hold_exp = 1'b0;
      pc_exp = 4'h0;
      pc_chk();
      pcw(4'h9);
      rd_chk(msc_pkg::IDX_BG_TRIM_LOW);
      rd_chk(msc_pkg::IDX_FOSC_TRIM);
      $display("test hold_flag done");

      ram[0] = msc_pkg::IDX_RAM_FIRST;
      ram[1] = msc_pkg::IDX_RAM_LAST;
      ram[2] = 9'h11F;
      ram[3] = 9'h170;
      for (int k = 4; k < 12; k++) ram[k] = msc_pkg::IDX_RAM_FIRST + 9'($urandom_range(79));
      foreach (ram[k]) wr(ram[k], $urandom);
      foreach (ram[k]) rd_chk(ram[k]);
      $display("test ram_bank done");
      finish_test();
   end

   initial begin
      repeat (20000) @(posedge ref_clk);
      miscompares++;
      $display("MISMATCH watchdog expected done seen hang");
      finish_test();
   end

endmodule : tb
